// >>> design/pin_lvd_interrupt_wakeup.sv
// pin, pin-change and supply-detect interrupts with idle and halt wake-up
// assumes an AXI4-Lite master on aclk; core pulses int_ack on vector entry
//
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/100ps
module pin_lvd_interrupt_wakeup (
  input  wire logic                           aclk,
  input  wire logic                           aresetn,
  input  wire logic                           s_axi_awvalid,
  output logic                                s_axi_awready,
  input  wire logic [pin_irq_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                           s_axi_wvalid,
  output logic                                s_axi_wready,
  input  wire logic [31:0]                    s_axi_wdata,
  input  wire logic [3:0]                     s_axi_wstrb,
  output logic                                s_axi_bvalid,
  input  wire logic                           s_axi_bready,
  output logic      [1:0]                     s_axi_bresp,
  input  wire logic                           s_axi_arvalid,
  output logic                                s_axi_arready,
  input  wire logic [pin_irq_pkg::ADDR_W-1:0] s_axi_araddr,
  output logic                                s_axi_rvalid,
  input  wire logic                           s_axi_rready,
  output logic      [31:0]                    s_axi_rdata,
  output logic      [1:0]                     s_axi_rresp,
  input  wire logic                           ext_irq_pin_a,
  input  wire logic                           ext_irq_pin_b,
  input  wire logic [7:0]                     port0_pins,
  input  wire logic [7:0]                     port1_pins,
  input  wire logic [7:0]                     port3_pins,
  input  wire logic                           supply_below,
  input  wire logic [2:0]                     other_flag_set,
  input  wire logic                           nvm_write_pending,
  input  wire logic [1:0]                     int_ack,
  output logic                                irq_ext_a,
  output logic                                irq_ext_b,
  output logic                                irq_pin_change,
  output logic                                irq_supply,
  output logic                                cpu_idle,
  output logic                                cpu_halt,
  output logic      [3:0]                     supply_threshold_select,
  output logic                                supply_detect_powerdown
);
  import pin_irq_pkg::*;

  function automatic logic is_mapped(input logic [7:0] idx);
    case (idx)
      IDX_PORT_FLAGS, IDX_POWER, IDX_TIMER_AND_EXT_INT_CONTROL, IDX_PORT_SEL, IDX_COMB,
      IDX_PIN_FLAGS, IDX_WAKE_MASK, IDX_IE_MAIN, IDX_IE_EXTRA,
      IDX_SUPPLY: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction

  logic              aw_held_ff;
  logic              w_held_ff;
  logic              bvalid_ff;
  logic              rvalid_ff;
  logic [ADDR_W-1:0] awaddr_ff;
  logic [7:0]        wdata_ff;
  logic              wstrb_ff;
  logic [1:0]        bresp_ff;
  logic [1:0]        rresp_ff;
  logic [31:0]       rdata_ff;
  logic [7:0]        rd_byte;
  logic [7:0]        rd_idx;
  logic [7:0]        wr_idx;
  logic [7:0]        wb;
  logic              wr_go;
  logic              wr_en;

  logic [7:0]        timer_and_ext_int_control_ff;
  logic [7:0]        nxt_timer_and_ext_int_control;
  logic [7:0]        ie_main_ff;
  logic [7:0]        ie_extra_ff;
  logic [7:0]        sup_setup_ff;
  logic [7:0]        pmisc_ff;
  port_sel_e         psel_ff;
  logic [7:0]        wake_mask_ff [NUM_PORTS];
  logic              sum_flag_ff;
  logic              sup_flag_ff;
  logic [2:0]        misc_flag_ff;
  pwr_state_e        pwr_state_ff;
  logic [WARM_W-1:0] warm_cnt_ff;

  logic [1:0]        ext_lvl;
  logic [1:0]        ext_fell;
  logic [23:0]       port_chg;
  logic              sup_lvl;
  logic              sup_chg;
  logic              sup_rise;
  logic [1:0]        sel_bank;
  logic [7:0]        bank_flags [NUM_PORTS];
  logic [2:0]        port_flag;
  logic [2:0]        any_chg;
  logic              comb_wr;
  logic              sum_clear;
  logic              ea;
  logic              low_a;
  logic              low_b;
  logic              req_a;
  logic              req_b;
  logic              req_pc;
  logic              req_sup;
  logic              req_any;
  logic              pin_hold;
  logic              halt_wake;
  logic              hold;

  // write channel: address and data taken in either order
  assign s_axi_awready = ~aw_held_ff & ~bvalid_ff;
  assign s_axi_wready  = ~w_held_ff & ~bvalid_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign wr_go         = aw_held_ff & w_held_ff & ~bvalid_ff;
  assign wr_idx        = awaddr_ff[ADDR_W-1:2];
  assign wb            = wdata_ff;
  assign wr_en         = wr_go & wstrb_ff & is_mapped(wr_idx);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'b0;
      w_held_ff  <= 1'b0;
      bvalid_ff  <= 1'b0;
      awaddr_ff  <= '0;
      wdata_ff   <= RST_BYTE;
      wstrb_ff   <= 1'b0;
      bresp_ff   <= RESP_OK;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_ff <= 1'b1;
        awaddr_ff  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_ff <= 1'b1;
        wdata_ff  <= s_axi_wdata[7:0];
        wstrb_ff  <= s_axi_wstrb[0];
      end
      if (wr_go) begin
        aw_held_ff <= 1'b0;
        w_held_ff  <= 1'b0;
        bvalid_ff  <= 1'b1;
        bresp_ff   <= is_mapped(wr_idx) ? RESP_OK : RESP_DECERR;
      end else if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // read channel: one cycle from address to data
  assign s_axi_arready = ~rvalid_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;
  assign rd_idx        = s_axi_araddr[ADDR_W-1:2];

  always_comb begin
    case (rd_idx)
      IDX_PORT_FLAGS: rd_byte = {4'h0, port_flag[2], 1'b0, port_flag[1:0]};
      IDX_POWER:      rd_byte = {pmisc_ff[7], 3'h0, pmisc_ff[3:2],
                                 pwr_state_ff == P_HALT, pwr_state_ff == P_IDLE};
      IDX_TIMER_AND_EXT_INT_CONTROL:       rd_byte = timer_and_ext_int_control_ff;
      IDX_PORT_SEL:   rd_byte = {6'h00, psel_ff};
      IDX_COMB:       rd_byte = {sup_flag_ff, misc_flag_ff[2], nvm_write_pending,
                                 misc_flag_ff[1], 2'b00, sum_flag_ff, misc_flag_ff[0]};
      IDX_PIN_FLAGS:  rd_byte = bank_flags[sel_bank];
      IDX_WAKE_MASK:  rd_byte = wake_mask_ff[sel_bank];
      IDX_IE_MAIN:    rd_byte = ie_main_ff;
      IDX_IE_EXTRA:   rd_byte = ie_extra_ff;
      IDX_SUPPLY:     rd_byte = {sup_setup_ff[7], sup_lvl, sup_setup_ff[5:0]};
      default:        rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
      rresp_ff  <= RESP_OK;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= {24'h00_0000, rd_byte};
      rresp_ff  <= is_mapped(rd_idx) ? RESP_OK : RESP_DECERR;
    end else if (rvalid_ff && s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  // pin synchronisers
  pin_sync #(.W(2)) u_ext_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in ({ext_irq_pin_b, ext_irq_pin_a}),
    .level    (ext_lvl),
    .changed  (),
    .fell     (ext_fell)
  );

  pin_sync #(.W(24)) u_port_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in ({port3_pins, port1_pins, port0_pins}),
    .level    (),
    .changed  (port_chg),
    .fell     ()
  );

  pin_sync #(.W(1)) u_sup_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in (supply_below),
    .level    (sup_lvl),
    .changed  (sup_chg),
    .fell     ()
  );

  assign sup_rise = sup_chg & sup_lvl;

  // banks 0,1,2 serve ports 0,1,3
  assign sel_bank  = (psel_ff == PSEL_P3) ? 2'd2 : {1'b0, psel_ff[0]};
  assign comb_wr   = wr_en && (wr_idx == IDX_COMB);
  assign sum_clear = comb_wr && !wb[B_SUMMARY];

  chg_bank_if cb [NUM_PORTS] ();

  for (genvar g = 0; g < NUM_PORTS; g++) begin : g_bank
    localparam int POS = (g == 2) ? 3 : g;
    // mode bits enable both change detection and halt wake
    assign cb[g].chg      = port_chg[8*g +: 8] & wake_mask_ff[g];
    assign cb[g].clr_all  = sum_clear;
    assign cb[g].clr_port = wr_en && (wr_idx == IDX_PORT_FLAGS) && !wb[POS];
    assign cb[g].clr_pin  = (wr_en && (wr_idx == IDX_PIN_FLAGS) && sel_bank == 2'(g))
                            ? ~wb : 8'h00;
    assign bank_flags[g]  = cb[g].flags;
    assign port_flag[g]   = cb[g].port_flag;
    assign any_chg[g]     = |cb[g].chg;
    change_bank u_bank (
      .aclk    (aclk),
      .aresetn (aresetn),
      .b       (cb[g].bank)
    );
  end

  // plain control registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ie_main_ff   <= RST_BYTE;
      ie_extra_ff  <= RST_BYTE;
      sup_setup_ff <= RST_BYTE;
      pmisc_ff     <= RST_BYTE;
      psel_ff      <= PSEL_P0;
      wake_mask_ff <= '{default: RST_BYTE};
    end else if (wr_en) begin
      case (wr_idx)
        IDX_IE_MAIN:   ie_main_ff <= wb & IE_MAIN_WMASK;
        IDX_IE_EXTRA:  ie_extra_ff <= wb;
        IDX_SUPPLY:    sup_setup_ff <= wb & SUPPLY_WMASK;
        IDX_POWER:     pmisc_ff <= wb & POWER_WMASK;
        // the reserved code is dropped, the old port stays selected
        IDX_PORT_SEL:  if (wb[1:0] != PSEL_RSVD) psel_ff <= port_sel_e'(wb[1:0]);
        IDX_WAKE_MASK: wake_mask_ff[sel_bank] <= wb;
        default:       ;
      endcase
    end
  end

  assign supply_threshold_select = sup_setup_ff[3:0];
  assign supply_detect_powerdown = sup_setup_ff[B_SUP_PD];

  // edge flags: pin edge wins over vector entry and software write
  always_comb begin
    nxt_timer_and_ext_int_control = timer_and_ext_int_control_ff;
    if (wr_en && (wr_idx == IDX_TIMER_AND_EXT_INT_CONTROL)) nxt_timer_and_ext_int_control = wb;
    if (int_ack[0]) nxt_timer_and_ext_int_control[B_EDGE_A] = 1'b0;
    if (int_ack[1]) nxt_timer_and_ext_int_control[B_EDGE_B] = 1'b0;
    if (ext_fell[0]) nxt_timer_and_ext_int_control[B_EDGE_A] = 1'b1;
    if (ext_fell[1]) nxt_timer_and_ext_int_control[B_EDGE_B] = 1'b1;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) timer_and_ext_int_control_ff <= RST_BYTE;
    else          timer_and_ext_int_control_ff <= nxt_timer_and_ext_int_control;
  end

  // combined flags: set wins over a clearing write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sum_flag_ff  <= 1'b0;
      sup_flag_ff  <= 1'b0;
      misc_flag_ff <= 3'b000;
    end else begin
      sum_flag_ff <= (sum_flag_ff & ~sum_clear) | (|any_chg);
      sup_flag_ff <= (sup_flag_ff & ~(comb_wr && wb == CLR_SUP_CODE))
                     | (sup_rise & ~sup_setup_ff[B_SUP_PD]);
      misc_flag_ff <= (misc_flag_ff & ~({3{comb_wr}} &
                       ~{wb[B_NVM_DONE], wb[B_CONV], wb[B_T3_FLAG]})) | other_flag_set;
    end
  end

  // requests
  assign ea      = ie_main_ff[B_GLOBAL];
  assign low_a   = ~ext_lvl[0];
  assign low_b   = ~ext_lvl[1];
  assign req_a   = ea & ie_main_ff[B_EN_A]
                   & (timer_and_ext_int_control_ff[B_TYPE_A] ? timer_and_ext_int_control_ff[B_EDGE_A] : low_a);
  assign req_b   = ea & ie_main_ff[B_EN_B]
                   & (timer_and_ext_int_control_ff[B_TYPE_B] ? timer_and_ext_int_control_ff[B_EDGE_B] : low_b);
  assign req_pc  = ea & ie_extra_ff[B_PCIE] & sum_flag_ff;
  assign req_sup = ea & ie_extra_ff[B_SUPIE] & sup_flag_ff;
  assign req_any = req_a | req_b | req_pc | req_sup;
  assign hold    = (pwr_state_ff == P_HALT) || (pwr_state_ff == P_WARM);

  // halt wake ignores global and pin-change enables
  assign pin_hold  = (ie_main_ff[B_EN_A] & low_a) | (ie_main_ff[B_EN_B] & low_b);
  assign halt_wake = pin_hold | (|any_chg);

  // requests stay off until warm-up ends so the core resumes first
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_ext_a      <= 1'b0;
      irq_ext_b      <= 1'b0;
      irq_pin_change <= 1'b0;
      irq_supply     <= 1'b0;
    end else begin
      irq_ext_a      <= req_a & ~hold;
      irq_ext_b      <= req_b & ~hold;
      irq_pin_change <= req_pc & ~hold;
      irq_supply     <= req_sup & ~hold;
    end
  end

  // power modes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pwr_state_ff <= P_RUN;
      warm_cnt_ff  <= '0;
    end else begin
      case (pwr_state_ff)
        P_RUN: begin
          if (wr_en && (wr_idx == IDX_POWER)) begin
            if (wb[B_PD] && !pin_hold) pwr_state_ff <= P_HALT;
            else if (wb[B_IDL]) pwr_state_ff <= P_IDLE;
          end
        end
        P_IDLE: begin
          if (req_any) pwr_state_ff <= P_RUN;
        end
        P_HALT: begin
          if (halt_wake) begin
            pwr_state_ff <= P_WARM;
            warm_cnt_ff  <= WARM_W'(WARMUP_CYC - 1);
          end
        end
        P_WARM: begin
          if (warm_cnt_ff == '0) pwr_state_ff <= P_RUN;
          else warm_cnt_ff <= warm_cnt_ff - 1'b1;
        end
        default: pwr_state_ff <= P_RUN;
      endcase
    end
  end

  assign cpu_idle = (pwr_state_ff == P_IDLE);
  assign cpu_halt = (pwr_state_ff == P_HALT);

  default clocking cb_clk @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  property p_level_req;
    !timer_and_ext_int_control_ff[B_TYPE_A] && ea && ie_main_ff[B_EN_A] && low_a && !hold |=> irq_ext_a;
  endproperty
  a_level_req: assert property (p_level_req) else $error("level request lost");

  property p_edge_set;
    ext_fell[0] |=> timer_and_ext_int_control_ff[B_EDGE_A] ##1
      (timer_and_ext_int_control_ff[B_EDGE_A] || $past(int_ack[0]) || $past(wr_en && wr_idx == IDX_TIMER_AND_EXT_INT_CONTROL));
  endproperty
  a_edge_set: assert property (p_edge_set) else $error("edge flag not set");

  property p_edge_ack;
    int_ack[1] && !ext_fell[1] |=> !timer_and_ext_int_control_ff[B_EDGE_B];
  endproperty
  a_edge_ack: assert property (p_edge_ack) else $error("edge flag not cleared");

  property p_global_off;
    !ea |=> !(irq_ext_a || irq_ext_b || irq_pin_change || irq_supply);
  endproperty
  a_global_off: assert property (p_global_off) else $error("request without global");

  property p_halt_wake;
    pwr_state_ff == P_HALT && ie_main_ff[B_EN_A] && low_a |=> pwr_state_ff == P_WARM;
  endproperty
  a_halt_wake: assert property (p_halt_wake) else $error("halt not woken by pin");

  property p_refuse;
    pwr_state_ff == P_RUN && wr_en && wr_idx == IDX_POWER && wb[B_PD] && pin_hold
      |=> pwr_state_ff != P_HALT;
  endproperty
  a_refuse: assert property (p_refuse) else $error("halt entered with pin low");

  property p_sum_clr;
    sum_clear && any_chg == 3'b000 |=> !sum_flag_ff && port_flag == 3'b000;
  endproperty
  a_sum_clr: assert property (p_sum_clr) else $error("summary clear incomplete");

  property p_sup_clr;
    comb_wr && wb == CLR_SUP_CODE && !sup_rise |=> !sup_flag_ff;
  endproperty
  a_sup_clr: assert property (p_sup_clr) else $error("supply flag not cleared");

  property p_warm_gate;
    pwr_state_ff == P_HALT && halt_wake |=> (!irq_ext_a && !irq_pin_change) [*8];
  endproperty
  a_warm_gate: assert property (p_warm_gate) else $error("request during warm-up");

  property p_idle_wake;
    pwr_state_ff == P_IDLE && req_any |=> pwr_state_ff == P_RUN;
  endproperty
  a_idle_wake: assert property (p_idle_wake) else $error("idle not woken");

  c_halt_wake: cover property (pwr_state_ff == P_HALT ##1 pwr_state_ff == P_WARM);
  c_idle_wake: cover property (pwr_state_ff == P_IDLE ##1 pwr_state_ff == P_RUN);
  c_sup_irq:   cover property ($rose(irq_supply));
  c_pc_irq:    cover property ($rose(irq_pin_change));
endmodule

// >>> include/pin_irq_pkg.sv
// constants for the pin, pin-change and supply-detect interrupt block
// assumes byte-wide registers, one per aligned 32-bit word on the bus
package pin_irq_pkg;
  localparam int ADDR_W    = 10;
  localparam int NUM_PORTS = 3;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_PORT_FLAGS = 8'h85;
  localparam logic [7:0] IDX_POWER      = 8'h87;
  localparam logic [7:0] IDX_TIMER_AND_EXT_INT_CONTROL       = 8'h88;
  localparam logic [7:0] IDX_PORT_SEL   = 8'h91;
  localparam logic [7:0] IDX_COMB       = 8'h95;
  localparam logic [7:0] IDX_PIN_FLAGS  = 8'h96;
  localparam logic [7:0] IDX_WAKE_MASK  = 8'h9c;
  localparam logic [7:0] IDX_IE_MAIN    = 8'ha8;
  localparam logic [7:0] IDX_IE_EXTRA   = 8'ha9;
  localparam logic [7:0] IDX_SUPPLY     = 8'hbf;

  // field positions
  localparam int B_TYPE_A   = 0;
  localparam int B_EDGE_A   = 1;
  localparam int B_TYPE_B   = 2;
  localparam int B_EDGE_B   = 3;
  localparam int B_EN_A     = 0;
  localparam int B_EN_B     = 2;
  localparam int B_GLOBAL   = 7;
  localparam int B_PCIE     = 1;
  localparam int B_SUPIE    = 2;
  localparam int B_T3_FLAG  = 0;
  localparam int B_SUMMARY  = 1;
  localparam int B_CONV     = 4;
  localparam int B_NVM_BUSY = 5;
  localparam int B_NVM_DONE = 6;
  localparam int B_SUP_FLAG = 7;
  localparam int B_IDL      = 0;
  localparam int B_PD       = 1;
  localparam int B_SUP_PD   = 7;
  localparam int B_SUP_OUT  = 6;

  // writable bit masks and reset values
  localparam logic [7:0] RST_BYTE      = 8'h00;
  localparam logic [7:0] POWER_WMASK   = 8'h8c;
  localparam logic [7:0] IE_MAIN_WMASK = 8'hbf;
  localparam logic [7:0] SUPPLY_WMASK  = 8'h9f;
  localparam logic [7:0] CLR_SUP_CODE  = 8'h7f;

  localparam logic [1:0] RESP_OK     = 2'b00;
  localparam logic [1:0] RESP_DECERR = 2'b11;

  // warm-up after a halt wake before requests reach the core
  localparam int WARMUP_NS  = 1000;
  localparam int CLK_NS     = 5;
  localparam int WARMUP_CYC = (WARMUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int WARM_W     = 8;

  typedef enum logic [1:0] {
    PSEL_P0   = 2'b00,
    PSEL_P1   = 2'b01,
    PSEL_RSVD = 2'b10,
    PSEL_P3   = 2'b11
  } port_sel_e;

  typedef enum logic [1:0] {
    P_RUN  = 2'b00,
    P_IDLE = 2'b01,
    P_HALT = 2'b10,
    P_WARM = 2'b11
  } pwr_state_e;
endpackage

// >>> include/chg_bank_if.sv
// carrier between the controller and one port's change-flag bank
// assumes both ends on the same clock
`timescale 1ns/100ps
interface chg_bank_if;
  logic [7:0] chg;
  logic [7:0] clr_pin;
  logic       clr_all;
  logic       clr_port;
  logic [7:0] flags;
  logic       port_flag;
  modport bank (input chg, clr_pin, clr_all, clr_port, output flags, port_flag);
  modport ctl  (output chg, clr_pin, clr_all, clr_port, input flags, port_flag);
endinterface

// >>> design/pin_sync.sv
// two-stage synchroniser with change and falling-edge detect
// assumes async_in comes from pins outside the aclk domain
`timescale 1ns/100ps
module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] level,
  output logic      [W-1:0] changed,
  output logic      [W-1:0] fell
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;
  logic [W-1:0] prev_ff;

  // idle pins sit high, so reset to ones avoids a false edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_ff <= '1;
      sync_ff <= '1;
      prev_ff <= '1;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  assign level   = sync_ff;
  assign changed = sync_ff ^ prev_ff;
  assign fell    = prev_ff & ~sync_ff;
endmodule

// >>> design/change_bank.sv
// per-pin and per-port change flags for one port
// assumes clears come as one-cycle strobes from the register file
`timescale 1ns/100ps
module change_bank (
  input wire logic aclk,
  input wire logic aresetn,
  chg_bank_if.bank b
);
  import pin_irq_pkg::*;
  logic [7:0] flags_ff;
  logic       port_ff;

  // a change in the clearing cycle still sets the flag
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_ff <= RST_BYTE;
      port_ff  <= 1'b0;
    end else begin
      flags_ff <= (flags_ff & ~b.clr_pin & {8{~b.clr_all}}) | b.chg;
      port_ff  <= (port_ff & ~b.clr_port & ~b.clr_all) | (|b.chg);
    end
  end

  assign b.flags     = flags_ff;
  assign b.port_flag = port_ff;
endmodule

// >>> testbench/core_ack_model.sv
// core side model: enters service of pin requests with an ack pulse
// assumes registered request levels on aclk
`timescale 1ns/100ps
module core_ack_model (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       irq_ext_a,
  input  wire logic       irq_ext_b,
  output logic      [1:0] int_ack
);
  // gap cycle between acks stands in for the vector fetch
  always_ff @(posedge aclk) begin
    if (!aresetn) int_ack <= 2'b00;
    else int_ack <= {irq_ext_b, irq_ext_a} & ~int_ack;
  end
endmodule

// >>> testbench/pin_lvd_interrupt_wakeup_test.sv
// bench for the pin, pin-change and supply interrupt block
// assumes the core model acks pin requests
`timescale 1ns/100ps
module pin_lvd_interrupt_wakeup_test;
  import pin_irq_pkg::*;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [9:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb, supply_threshold_select;
  logic [1:0] s_axi_bresp, s_axi_rresp, int_ack, r;
  logic [7:0] port0_pins, port1_pins, port3_pins, q;
  logic [2:0] other_flag_set;
  logic ext_irq_pin_a, ext_irq_pin_b, supply_below, nvm_write_pending, irq_ext_a, irq_ext_b;
  logic irq_pin_change, irq_supply, cpu_idle, cpu_halt, supply_detect_powerdown;
  int bad_count, n_checks;
  pin_lvd_interrupt_wakeup pin_lvd_interrupt_wakeup_i (.*);
  core_ack_model core_ack_model_i (.*);
  initial begin
    aclk = 0;
    forever #2.5 aclk = ~aclk;
  end
  task results;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input string n, input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask
  // handshakes judged at the falling edge, so released just after the taking edge
  task bus(input logic w, input logic [9:0] a, input logic [7:0] d);
    int i;
    logic ta, tw, tb;
    @(posedge aclk);
    if (w) begin
      s_axi_awvalid <= 1; s_axi_awaddr <= a; s_axi_wvalid <= 1;
      s_axi_wdata <= {24'h0, d}; s_axi_bready <= 1;
    end else begin
      s_axi_arvalid <= 1; s_axi_araddr <= a; s_axi_rready <= 1;
    end
    tb = 0;
    for (i = 0; i < 50 && !tb; i++) begin
      @(negedge aclk);
      ta = w ? s_axi_awvalid && s_axi_awready : s_axi_arvalid && s_axi_arready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = w ? s_axi_bvalid : s_axi_rvalid;
      q = s_axi_rdata[7:0];
      r = w ? s_axi_bresp : s_axi_rresp;
      @(posedge aclk);
      if (ta) begin s_axi_awvalid <= 0; s_axi_arvalid <= 0; end
      if (tw) s_axi_wvalid <= 0;
      if (tb) begin s_axi_bready <= 0; s_axi_rready <= 0; end
    end
    if (!tb) begin bad_count++; results; end
  endtask
  task wr(input logic [7:0] x, input logic [7:0] d);
    bus(1, {x, 2'b00}, d);
  endtask
  task rc(input string n, input logic [7:0] x, input logic [7:0] e);
    bus(0, {x, 2'b00}, 8'h00);
    chk(n, q, e);
  endtask
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {supply_below, nvm_write_pending, other_flag_set, s_axi_awaddr, s_axi_araddr} = '0;
    s_axi_wdata = '0; s_axi_wstrb = 4'h1; {ext_irq_pin_a, ext_irq_pin_b} = 2'b11;
    {port0_pins, port1_pins, port3_pins} = '1;
    repeat (3) @(posedge aclk);
    aresetn <= 1;
    repeat (4) @(posedge aclk);
    rc("enable_main", IDX_IE_MAIN, 8'h00);
    bus(0, 10'h000, 8'h00);
    chk("unmapped_resp", {6'h0, r}, 8'h03);
    $display("test reset done");
    wr(IDX_TIMER_AND_EXT_INT_CONTROL, 8'h01);
    ext_irq_pin_a <= 0;
    repeat (6) @(posedge aclk);
    rc("timer_and_ext_int_control", IDX_TIMER_AND_EXT_INT_CONTROL, 8'h03);
    @(negedge aclk);
    chk("irq_a", {7'h0, irq_ext_a}, 8'h00);
    ext_irq_pin_a <= 1;
    wr(IDX_IE_MAIN, 8'h81);
    repeat (6) @(posedge aclk);
    rc("timer_and_ext_int_control", IDX_TIMER_AND_EXT_INT_CONTROL, 8'h01);
    $display("test edge done");
    wr(IDX_TIMER_AND_EXT_INT_CONTROL, 8'h00);
    wr(IDX_IE_MAIN, 8'h01);
    ext_irq_pin_a <= 0;
    repeat (6) @(posedge aclk);
    @(negedge aclk);
    chk("irq_a", {7'h0, irq_ext_a}, 8'h00);
    wr(IDX_POWER, 8'h02);
    repeat (3) @(posedge aclk);
    @(negedge aclk);
    chk("halt", {7'h0, cpu_halt}, 8'h00);
    wr(IDX_IE_MAIN, 8'h81);
    repeat (4) @(posedge aclk);
    @(negedge aclk);
    chk("irq_a", {7'h0, irq_ext_a}, 8'h01);
    @(posedge aclk);
    ext_irq_pin_a <= 1;
    repeat (6) @(posedge aclk);
    @(negedge aclk);
    chk("irq_a", {7'h0, irq_ext_a}, 8'h00);
    wr(IDX_IE_MAIN, 8'h00);
    $display("test level done");
    wr(IDX_WAKE_MASK, 8'h01);
    port0_pins[0] <= 0;
    repeat (6) @(posedge aclk);
    rc("comb", IDX_COMB, 8'h02);
    other_flag_set <= 3'b001;
    @(posedge aclk);
    other_flag_set <= 3'b000;
    wr(IDX_COMB, 8'hff);
    rc("comb", IDX_COMB, 8'h03);
    rc("port_flags", IDX_PORT_FLAGS, 8'h01);
    rc("pin_flags", IDX_PIN_FLAGS, 8'h01);
    wr(IDX_COMB, 8'h00);
    rc("pin_flags", IDX_PIN_FLAGS, 8'h00);
    rc("port_flags", IDX_PORT_FLAGS, 8'h00);
    $display("test change done");
    supply_below <= 1;
    repeat (6) @(posedge aclk);
    rc("comb", IDX_COMB, 8'h80);
    @(negedge aclk);
    chk("irq_supply", {7'h0, irq_supply}, 8'h00);
    wr(IDX_COMB, 8'h00);
    rc("comb", IDX_COMB, 8'h80);
    wr(IDX_IE_EXTRA, 8'h04);
    wr(IDX_IE_MAIN, 8'h80);
    @(negedge aclk);
    chk("irq_supply", {7'h0, irq_supply}, 8'h01);
    wr(IDX_COMB, CLR_SUP_CODE);
    rc("comb", IDX_COMB, 8'h00);
    wr(IDX_SUPPLY, 8'h8a);
    rc("supply", IDX_SUPPLY, 8'hca);
    chk("sel", {4'h0, supply_threshold_select}, 8'h0a);
    chk("pd", {7'h0, supply_detect_powerdown}, 8'h01);
    $display("test supply done");
    wr(IDX_IE_MAIN, 8'h81);
    wr(IDX_POWER, 8'h02);
    @(negedge aclk);
    chk("halt", {7'h0, cpu_halt}, 8'h01);
    repeat (2) @(posedge aclk);
    ext_irq_pin_a <= 0;
    repeat (WARMUP_CYC - 10) @(posedge aclk);
    @(negedge aclk);
    chk("halt", {7'h0, cpu_halt}, 8'h00);
    chk("irq_a", {7'h0, irq_ext_a}, 8'h00);
    repeat (20) @(posedge aclk);
    @(negedge aclk);
    chk("irq_a", {7'h0, irq_ext_a}, 8'h01);
    @(posedge aclk);
    ext_irq_pin_a <= 1;
    wr(IDX_POWER, 8'h02);
    port0_pins[0] <= 1;
    repeat (6) @(posedge aclk);
    @(negedge aclk);
    chk("halt", {7'h0, cpu_halt}, 8'h00);
    repeat (WARMUP_CYC) @(posedge aclk);
    $display("test halt done");
    wr(IDX_COMB, 8'h00);
    wr(IDX_IE_EXTRA, 8'h02);
    wr(IDX_POWER, 8'h01);
    @(negedge aclk);
    chk("idle", {7'h0, cpu_idle}, 8'h01);
    @(posedge aclk);
    port0_pins[0] <= 0;
    repeat (6) @(posedge aclk);
    @(negedge aclk);
    chk("idle", {7'h0, cpu_idle}, 8'h00);
    chk("irq_pc", {7'h0, irq_pin_change}, 8'h01);
    wr(IDX_PORT_SEL, 8'h02);
    rc("port_sel", IDX_PORT_SEL, 8'h00);
    wr(IDX_PORT_SEL, 8'h03);
    rc("port_sel", IDX_PORT_SEL, 8'h03);
    $display("test idle done");
    results;
  end
endmodule
